// >>> design/bmeu_pkg.sv
// Purpose: shared constants, op codes and carriers of the branch/multiply execution unit
// Assumes: 32-bit apb data, byte addresses, one aligned word per register
// Notes:   status flag bit order is c z n v s h t i from bit 0 upward
package bmeu_pkg;
   // ****************************************************
   // register map (byte offsets)
   // ****************************************************
   localparam logic [7:0]  OFF_OP   = 8'h00;
   localparam logic [7:0]  OFF_OPND = 8'h04;
   localparam logic [7:0]  OFF_PC   = 8'h08;
   localparam logic [7:0]  OFF_ZPTR = 8'h0c;
   localparam logic [7:0]  OFF_STK  = 8'h10;
   localparam logic [7:0]  OFF_KOFF = 8'h14;
   localparam logic [7:0]  OFF_FLAG = 8'h18;
   localparam logic [7:0]  OFF_PROD = 8'h1c;
   localparam logic [7:0]  OFF_STAT = 8'h20;
   // ****************************************************
   // status flag register bit positions
   // ****************************************************
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam int FLG_S = 4;
   localparam int FLG_H = 5;
   localparam int FLG_T = 6;
   localparam int FLG_I = 7;
   // status register bits
   localparam int STAT_BUSY  = 0;
   localparam int STAT_TAKEN = 1;
   localparam int STAT_DONE  = 2;
   // ****************************************************
   // widths, reset values, timing
   // ****************************************************
   localparam int          K_SIGN     = 11;
   localparam logic [15:0] PC_RST     = 16'h0000;
   localparam logic [7:0]  FLAG_RST   = 8'h00;
   localparam logic [15:0] PC_NEXT    = 16'h0001;
   localparam logic [15:0] PC_SKIP1   = 16'h0002;
   localparam logic [15:0] PC_SKIP2   = 16'h0003;
   localparam logic [2:0]  CNT_STEP   = 3'h1;
   localparam logic [2:0]  CYC_SINGLE = 3'h1;
   localparam logic [2:0]  CYC_MUL    = 3'h2;
   localparam logic [2:0]  CYC_JUMP   = 3'h2;
   localparam logic [2:0]  CYC_BR_TKN = 3'h2;
   localparam logic [2:0]  CYC_SKIP1  = 3'h2;
   localparam logic [2:0]  CYC_SKIP2  = 3'h3;
   localparam logic [2:0]  CYC_CALL   = 3'h3;
   localparam logic [2:0]  CYC_RET    = 3'h4;
   // ****************************************************
   // op codes and carriers
   // ****************************************************
   typedef enum logic [5:0] {
      OP_MIXED_SIGN_MULTIPLY, OP_FRACTIONAL_UNSIGNED_MULTIPLY,
      OP_FRACTIONAL_SIGNED_MULTIPLY, OP_FRACTIONAL_MIXED_MULTIPLY,
      OP_RELATIVE_JUMP, OP_INDIRECT_JUMP, OP_RELATIVE_SUBROUTINE_CALL,
      OP_INDIRECT_CALL, OP_CALL_EXIT, OP_INTERRUPT_EXIT,
      OP_COMPARE_SKIP_EQUAL, OP_COMPARE_REGISTERS, OP_COMPARE_WITH_CARRY,
      OP_COMPARE_IMMEDIATE, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
      OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET, OP_BRANCH_FLAG_SET,
      OP_BRANCH_FLAG_CLEAR, OP_BRANCH_ON_EQUAL, OP_BRANCH_ON_UNEQUAL,
      OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER,
      OP_BRANCH_UNSIGNED_LOWER, OP_BRANCH_NEGATIVE, OP_BRANCH_POSITIVE,
      OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LESS, OP_BRANCH_HALF_CARRY_SET,
      OP_BRANCH_HALF_CARRY_CLEAR, OP_BRANCH_TRANSFER_BIT_SET,
      OP_BRANCH_TRANSFER_BIT_CLEAR, OP_BRANCH_OVERFLOW_SET,
      OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_INTERRUPTS_ON
   } bmeu_op_t;

   // operand word: next-instruction length, bit select, io byte, rr/immediate, rd
   typedef struct packed {
      logic       two_word;
      logic [2:0] bsel;
      logic [7:0] io;
      logic [7:0] rr;
      logic [7:0] rd;
   } bmeu_opnd_t;
endpackage

// >>> design/bmeu_mul.sv
// Purpose: 8x8 multiplier with signed, mixed and fractional forms
// Assumes: operands stable while the core is busy
// Notes:   carry is product bit 15 before the fractional shift
`timescale 1ns/1ps
module bmeu_mul
   import bmeu_pkg::*;
(
   // request
   input  wire bmeu_op_t    op,
   input  wire logic [7:0]  a,
   input  wire logic [7:0]  b,
   // result
   output logic [15:0] prod,
   output logic        carry,
   output logic        zero
);
   logic        a_sgn;
   logic        b_sgn;
   logic        frac;
   logic [17:0] raw;

   // signedness of each operand and fractional shift
   always_comb begin
      a_sgn = (op != OP_FRACTIONAL_UNSIGNED_MULTIPLY);
      b_sgn = (op == OP_FRACTIONAL_SIGNED_MULTIPLY);
      frac  = (op != OP_MIXED_SIGN_MULTIPLY);
      raw   = 18'($signed({a_sgn & a[7], a}) * $signed({b_sgn & b[7], b}));
      prod  = frac ? {raw[14:0], 1'b0} : raw[15:0];
      carry = raw[15];
      zero  = (prod == 16'h0000);
   end
endmodule

// >>> design/bmeu_cond.sv
// Purpose: decides whether a skip or branch condition holds
// Assumes: flags and operands stable while the core is busy
// Notes:   for the generic branches the bit select chooses the flag
`timescale 1ns/1ps
module bmeu_cond
   import bmeu_pkg::*;
(
   // inputs
   input  wire bmeu_op_t    op,
   input  wire logic [7:0]  flg,
   input  wire bmeu_opnd_t  opnd,
   // result
   output logic        hold
);
   // condition per op, false for ops without a condition
   always_comb begin
      case (op)
         OP_COMPARE_SKIP_EQUAL:        hold = (opnd.rd == opnd.rr);
         OP_SKIP_REG_BIT_CLEAR:        hold = ~opnd.rr[opnd.bsel];
         OP_SKIP_REG_BIT_SET:          hold = opnd.rr[opnd.bsel];
         OP_SKIP_IO_BIT_CLEAR:         hold = ~opnd.io[opnd.bsel];
         OP_SKIP_IO_BIT_SET:           hold = opnd.io[opnd.bsel];
         OP_BRANCH_FLAG_SET:           hold = flg[opnd.bsel];
         OP_BRANCH_FLAG_CLEAR:         hold = ~flg[opnd.bsel];
         OP_BRANCH_ON_EQUAL:           hold = flg[FLG_Z];
         OP_BRANCH_ON_UNEQUAL:         hold = ~flg[FLG_Z];
         OP_BRANCH_NEGATIVE:           hold = flg[FLG_N];
         OP_BRANCH_POSITIVE:           hold = ~flg[FLG_N];
         OP_BRANCH_CARRY_SET:          hold = flg[FLG_C];
         OP_BRANCH_CARRY_CLEAR:        hold = ~flg[FLG_C];
         OP_BRANCH_SAME_OR_HIGHER:     hold = ~flg[FLG_C];
         OP_BRANCH_UNSIGNED_LOWER:     hold = flg[FLG_C];
         OP_BRANCH_SIGNED_GE:          hold = ~(flg[FLG_N] ^ flg[FLG_V]);
         OP_BRANCH_SIGNED_LESS:        hold = flg[FLG_N] ^ flg[FLG_V];
         OP_BRANCH_HALF_CARRY_SET:     hold = flg[FLG_H];
         OP_BRANCH_HALF_CARRY_CLEAR:   hold = ~flg[FLG_H];
         OP_BRANCH_TRANSFER_BIT_SET:   hold = flg[FLG_T];
         OP_BRANCH_TRANSFER_BIT_CLEAR: hold = ~flg[FLG_T];
         OP_BRANCH_OVERFLOW_SET:       hold = flg[FLG_V];
         OP_BRANCH_OVERFLOW_CLEAR:     hold = ~flg[FLG_V];
         OP_BRANCH_INTERRUPTS_ON:      hold = flg[FLG_I];
         default:                      hold = 1'b0;
      endcase
   end
endmodule

// >>> design/bmeu_core.sv
// Purpose: apb-driven execution unit for multiplies, jumps, calls, returns,
//          compares, skips and conditional branches
// Assumes: apb master on pclk; writes are refused while an op executes
// Notes:   writing the op register starts execution; busy lasts the op's cycles
//
// Function
// - mixed multiply: signed by unsigned, z c, 2 cycles
// - fractional multiplies shift product left, 2 cycles
// - relative or z jump, 2 cycles, flags kept
// - relative call pushes return, 3 cycles
// - indirect call to z pushes return, 3 cycles
// - compare-skip-equal skips next, 1/2/3 cycles
// - compares set z n v c h, one cycle
// - register bit skips skip next, 1/2/3 cycles
// - io bit skips skip next, 1/2/3 cycles
// - generic branch tests selected flag, 1/2 cycles
// - carry branches test c, add offset plus one
// - same-or-higher when c clear, lower when set
// - signed ge/lt test n xor v
// - half-carry branches test h, flags kept
// - transfer-bit branches test t, 1/2 cycles
// - overflow branches test v
// - interrupts-on branch tests i
`timescale 1ns/1ps
module bmeu_core
   import bmeu_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // execution status
   output logic             exec_busy
);
   // ****************************************************
   // declarations
   // ****************************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN  = 2'b10
   } bmeu_state_t;

   bmeu_state_t state_q;
   bmeu_op_t    op_q;
   bmeu_opnd_t  opnd_q;
   logic [15:0] pc_q;
   logic [15:0] zptr_q;
   logic [15:0] stk_q;
   logic [11:0] koff_q;
   logic [7:0]  flg_q;
   logic [15:0] prod_q;
   logic        taken_q;
   logic        done_q;
   logic [2:0]  cnt_q;

   logic        acc;
   logic        fire;
   logic        wr;
   logic        start;
   logic        last;
   logic        busy;
   logic        hold;
   logic [2:0]  need;
   logic [15:0] rel;
   logic [15:0] pc_d;
   logic [31:0] rd_data;
   logic        rd_err;
   logic [15:0] mprod;
   logic        mcarry;
   logic        mzero;
   logic        cin;
   logic [7:0]  dif;
   logic [7:0]  cmp_flg;

   // ****************************************************
   // helpers
   // ****************************************************
   bmeu_mul u_mul (
      .op    (op_q),
      .a     (opnd_q.rd),
      .b     (opnd_q.rr),
      .prod  (mprod),
      .carry (mcarry),
      .zero  (mzero)
   );

   bmeu_cond u_cond (
      .op   (op_q),
      .flg  (flg_q),
      .opnd (opnd_q),
      .hold (hold)
   );

   // ****************************************************
   // apb slave
   // ****************************************************
   // answer one cycle into the access phase; write lands on the pready edge
   assign acc   = psel & penable;
   assign fire  = acc & pready;
   assign wr    = fire & pwrite & ~pslverr;
   assign start = wr & (paddr == OFF_OP);
   assign busy  = (state_q == ST_RUN);
   assign exec_busy = state_q[1];

   // read mux and error decode
   always_comb begin
      rd_err  = 1'b0;
      rd_data = 32'h0000_0000;
      case (paddr)
         OFF_OP:   rd_data = {26'h0, op_q};
         OFF_OPND: rd_data = {4'h0, opnd_q};
         OFF_PC:   rd_data = {16'h0, pc_q};
         OFF_ZPTR: rd_data = {16'h0, zptr_q};
         OFF_STK:  rd_data = {16'h0, stk_q};
         OFF_KOFF: rd_data = {20'h0, koff_q};
         OFF_FLAG: rd_data = {24'h0, flg_q};
         OFF_PROD: rd_data = {16'h0, prod_q};
         OFF_STAT: rd_data = {29'h0, done_q, taken_q, busy};
         default:  rd_err  = 1'b1;
      endcase
      // writes are refused while busy and on read-only registers
      if (pwrite && (busy || paddr == OFF_PROD || paddr == OFF_STAT)) begin
         rd_err = 1'b1;
      end
   end

   // registered response
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= acc & ~pready;
         pslverr <= acc & ~pready & rd_err;
         prdata  <= (acc & ~pready & ~pwrite & ~rd_err) ? rd_data : 32'h0000_0000;
      end
   end

   // ****************************************************
   // execution timing
   // ****************************************************
   // cycles needed by the current op
   always_comb begin
      case (op_q)
         OP_MIXED_SIGN_MULTIPLY,
         OP_FRACTIONAL_UNSIGNED_MULTIPLY,
         OP_FRACTIONAL_SIGNED_MULTIPLY,
         OP_FRACTIONAL_MIXED_MULTIPLY:  need = CYC_MUL;
         OP_RELATIVE_JUMP,
         OP_INDIRECT_JUMP:              need = CYC_JUMP;
         OP_RELATIVE_SUBROUTINE_CALL,
         OP_INDIRECT_CALL:              need = CYC_CALL;
         OP_CALL_EXIT,
         OP_INTERRUPT_EXIT:             need = CYC_RET;
         OP_COMPARE_SKIP_EQUAL,
         OP_SKIP_REG_BIT_CLEAR,
         OP_SKIP_REG_BIT_SET,
         OP_SKIP_IO_BIT_CLEAR,
         OP_SKIP_IO_BIT_SET: begin
            // skipping a two-word instruction costs one more cycle
            need = !hold ? CYC_SINGLE : (opnd_q.two_word ? CYC_SKIP2 : CYC_SKIP1);
         end
         OP_COMPARE_REGISTERS,
         OP_COMPARE_WITH_CARRY,
         OP_COMPARE_IMMEDIATE:          need = CYC_SINGLE;
         default:                       need = hold ? CYC_BR_TKN : CYC_SINGLE;
      endcase
   end

   assign last = busy && (3'(cnt_q + CNT_STEP) == need);

   // state and cycle counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         cnt_q   <= 3'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               cnt_q <= 3'h0;
               if (start) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               cnt_q <= 3'(cnt_q + CNT_STEP);
               if (last) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               cnt_q   <= 3'h0;
            end
         endcase
      end
   end

   // ****************************************************
   // next program counter and compare flags
   // ****************************************************
   assign rel = 16'(pc_q + {{4{koff_q[K_SIGN]}}, koff_q} + PC_NEXT);

   always_comb begin
      case (op_q)
         OP_RELATIVE_JUMP,
         OP_RELATIVE_SUBROUTINE_CALL: pc_d = rel;
         OP_INDIRECT_JUMP,
         OP_INDIRECT_CALL:            pc_d = zptr_q;
         OP_CALL_EXIT,
         OP_INTERRUPT_EXIT:           pc_d = stk_q;
         OP_COMPARE_SKIP_EQUAL,
         OP_SKIP_REG_BIT_CLEAR,
         OP_SKIP_REG_BIT_SET,
         OP_SKIP_IO_BIT_CLEAR,
         OP_SKIP_IO_BIT_SET: begin
            pc_d = 16'(pc_q + (!hold ? PC_NEXT : (opnd_q.two_word ? PC_SKIP2 : PC_SKIP1)));
         end
         OP_MIXED_SIGN_MULTIPLY,
         OP_FRACTIONAL_UNSIGNED_MULTIPLY,
         OP_FRACTIONAL_SIGNED_MULTIPLY,
         OP_FRACTIONAL_MIXED_MULTIPLY,
         OP_COMPARE_REGISTERS,
         OP_COMPARE_WITH_CARRY,
         OP_COMPARE_IMMEDIATE:        pc_d = 16'(pc_q + PC_NEXT);
         default:                     pc_d = hold ? rel : 16'(pc_q + PC_NEXT);
      endcase
   end

   // subtract without storing; immediate travels in the rr field
   always_comb begin
      cin     = (op_q == OP_COMPARE_WITH_CARRY) & flg_q[FLG_C];
      dif     = 8'(opnd_q.rd - opnd_q.rr - {7'h0, cin});
      cmp_flg = flg_q;
      cmp_flg[FLG_H] = (~opnd_q.rd[3] & opnd_q.rr[3]) | (opnd_q.rr[3] & dif[3]) | (dif[3] & ~opnd_q.rd[3]);
      cmp_flg[FLG_C] = (~opnd_q.rd[7] & opnd_q.rr[7]) | (opnd_q.rr[7] & dif[7]) | (dif[7] & ~opnd_q.rd[7]);
      cmp_flg[FLG_V] = (opnd_q.rd[7] & ~opnd_q.rr[7] & ~dif[7]) | (~opnd_q.rd[7] & opnd_q.rr[7] & dif[7]);
      cmp_flg[FLG_N] = dif[7];
      // with carry, zero can only stay set, so multi-byte compares chain
      cmp_flg[FLG_Z] = (dif == 8'h00) & (~cin | flg_q[FLG_Z] | (op_q != OP_COMPARE_WITH_CARRY));
      if (op_q == OP_COMPARE_WITH_CARRY) begin
         cmp_flg[FLG_Z] = (dif == 8'h00) & flg_q[FLG_Z];
      end
   end

   // ****************************************************
   // architectural state
   // ****************************************************
   // program counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_q <= PC_RST;
      end else if (last) begin
         pc_q <= pc_d;
      end else if (wr && paddr == OFF_PC) begin
         pc_q <= pwdata[15:0];
      end
   end

   // stack slot: popped by returns, receives the return point on calls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stk_q <= PC_RST;
      end else if (last && (op_q == OP_RELATIVE_SUBROUTINE_CALL || op_q == OP_INDIRECT_CALL)) begin
         stk_q <= 16'(pc_q + PC_NEXT);
      end else if (wr && paddr == OFF_STK) begin
         stk_q <= pwdata[15:0];
      end
   end

   // status flags; only multiplies, compares and interrupt return touch them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flg_q <= FLAG_RST;
      end else if (last) begin
         case (op_q)
            OP_MIXED_SIGN_MULTIPLY,
            OP_FRACTIONAL_UNSIGNED_MULTIPLY,
            OP_FRACTIONAL_SIGNED_MULTIPLY,
            OP_FRACTIONAL_MIXED_MULTIPLY: begin
               flg_q[FLG_Z] <= mzero;
               flg_q[FLG_C] <= mcarry;
            end
            OP_COMPARE_REGISTERS,
            OP_COMPARE_WITH_CARRY,
            OP_COMPARE_IMMEDIATE:  flg_q <= cmp_flg;
            OP_INTERRUPT_EXIT:     flg_q[FLG_I] <= 1'b1;
            default:               flg_q <= flg_q;
         endcase
      end else if (wr && paddr == OFF_FLAG) begin
         flg_q <= pwdata[7:0];
      end
   end

   // product pair r1:r0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prod_q <= 16'h0000;
      end else if (last && (op_q <= OP_FRACTIONAL_MIXED_MULTIPLY)) begin
         prod_q <= mprod;
      end
   end

   // op, operands, z pointer and offset, loaded by software only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_q   <= OP_MIXED_SIGN_MULTIPLY;
         opnd_q <= '0;
         zptr_q <= 16'h0000;
         koff_q <= 12'h000;
      end else if (wr) begin
         case (paddr)
            OFF_OP:   op_q   <= bmeu_op_t'(pwdata[5:0]);
            OFF_OPND: opnd_q <= pwdata[27:0];
            OFF_ZPTR: zptr_q <= pwdata[15:0];
            OFF_KOFF: koff_q <= pwdata[11:0];
            default:  op_q   <= op_q;
         endcase
      end
   end

   // outcome flags: taken holds the last condition, done is sticky until next start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         taken_q <= 1'b0;
         done_q  <= 1'b0;
      end else if (last) begin
         taken_q <= hold;
         done_q  <= 1'b1;
      end else if (start) begin
         done_q  <= 1'b0;
      end
   end

   // ****************************************************
   // assertions
   // ****************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_mul_two_cycles: assert property ($rose(busy) && op_q == OP_MIXED_SIGN_MULTIPLY
      |-> busy [*2] ##1 !busy)
      else $error("mixed multiply not two cycles");
   a_frac_shifted: assert property (last && op_q == OP_FRACTIONAL_UNSIGNED_MULTIPLY
      |=> prod_q == 16'(({8'h00, opnd_q.rd} * {8'h00, opnd_q.rr}) << 1))
      else $error("fractional product not shifted");
   a_relative_jump_target: assert property (last && op_q == OP_RELATIVE_JUMP
      |=> pc_q == $past(rel) && flg_q == $past(flg_q))
      else $error("relative jump target wrong");
   a_relative_subroutine_call_push: assert property ($rose(busy) && op_q == OP_RELATIVE_SUBROUTINE_CALL
      |-> ##2 last ##1 stk_q == 16'($past(pc_q) + PC_NEXT))
      else $error("relative call timing or push wrong");
   a_indirect_call_target: assert property (last && op_q == OP_INDIRECT_CALL |=> pc_q == zptr_q)
      else $error("indirect call target wrong");
   a_interrupt_exit_restore: assert property ($rose(busy) && op_q == OP_INTERRUPT_EXIT
      |-> ##3 last ##1 (flg_q[FLG_I] && pc_q == stk_q))
      else $error("interrupt return wrong");
   a_compare_skip_equal_skip: assert property (last && op_q == OP_COMPARE_SKIP_EQUAL && hold
      |=> pc_q == 16'($past(pc_q) + ($past(opnd_q.two_word) ? PC_SKIP2 : PC_SKIP1)))
      else $error("compare skip distance wrong");
   a_cp_zero: assert property (start && pwdata[5:0] == OP_COMPARE_REGISTERS
      |=> ##1 !busy && flg_q[FLG_Z] == (opnd_q.rd == opnd_q.rr))
      else $error("compare zero flag wrong");
   a_branch_untaken: assert property ($rose(busy) && op_q >= OP_BRANCH_FLAG_SET && !hold |=> !busy)
      else $error("untaken branch longer than one cycle");
   a_signed_ge: assert property (last && op_q == OP_BRANCH_SIGNED_GE
      |=> pc_q == ((flg_q[FLG_N] == flg_q[FLG_V]) ? $past(rel) : 16'($past(pc_q) + PC_NEXT)))
      else $error("signed ge branch wrong");

   c_relative_subroutine_call: cover property (last && op_q == OP_RELATIVE_SUBROUTINE_CALL);
   c_skip_two: cover property (last && hold && opnd_q.two_word && op_q == OP_SKIP_IO_BIT_SET);
   c_branch_taken: cover property (last && hold && op_q == OP_BRANCH_ON_EQUAL);
   c_frac_mul: cover property (last && op_q == OP_FRACTIONAL_MIXED_MULTIPLY);
endmodule

// >>> test/bmeu_core_tb_top.sv
// Purpose: apb bench for the branch/multiply execution unit
// Assumes: each op is set up by register writes, then started by the op write
// Notes:   busy cycles are counted at the exec_busy port
`timescale 1ns/1ps
module bmeu_core_tb_top
   import bmeu_pkg::*;
;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, exec_busy, er;
   logic [7:0]  msk [19] = '{8'h40, 8'h40, 8'h02, 8'h02, 8'h01, 8'h01, 8'h01, 8'h01, 8'h04, 8'h04,
                             8'h04, 8'h04, 8'h20, 8'h20, 8'h40, 8'h40, 8'h08, 8'h08, 8'h80};
   logic [18:0] pol = 19'h55995;  // set when the branch is taken on the flag being one
   int          err_count = 0, check_count = 0;
   logic        tk;
   bmeu_core uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .exec_busy(exec_busy));
   // ****************************************************
   // clock, transfers and comparisons
   // ****************************************************
   always #2 pclk = ~pclk;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n == 20) chk(32'h1, 32'h0);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // set up and start one op, then count its busy cycles
   task run(input bmeu_op_t op, input logic [31:0] opnd, pc, flg, input int cyc);
      int n;
      apb(1'b1, OFF_OPND, opnd); apb(1'b1, OFF_PC, pc); apb(1'b1, OFF_FLAG, flg);
      apb(1'b1, OFF_OP, {26'h0, op});
      n = 0;
      for (int k = 0; k < 12; k++) begin
         @(posedge pclk);
         if (exec_busy === 1'b1) n++;
      end
      chk(n, cyc);
   endtask
   task end_of_test;
      $display("errors %0d of %0d checks", err_count, check_count);
      if (err_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #100000;
      err_count++;
      end_of_test;
   end
   // ****************************************************
   // scenarios
   // ****************************************************
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(OFF_PC, 32'h0);
      run(OP_MIXED_SIGN_MULTIPLY, 32'h02ff, 32'h10, 32'hfe, 2);
      rdchk(OFF_PROD, 32'hfffe); rdchk(OFF_FLAG, 32'hfd);
      run(OP_FRACTIONAL_MIXED_MULTIPLY, 32'h80ff, 32'h10, 32'hc0, 2);
      rdchk(OFF_PROD, 32'hff00); rdchk(OFF_FLAG, 32'hc1);
      run(OP_FRACTIONAL_UNSIGNED_MULTIPLY, 32'hffff, 32'h10, 32'h02, 2);
      rdchk(OFF_PROD, 32'hfc02); rdchk(OFF_FLAG, 32'h01);
      run(OP_FRACTIONAL_SIGNED_MULTIPLY, 32'h8080, 32'h10, 32'h03, 2);
      rdchk(OFF_PROD, 32'h8000); rdchk(OFF_FLAG, 32'h00);
      apb(1'b1, OFF_KOFF, 32'h800);
      run(OP_RELATIVE_JUMP, 32'h0, 32'h1000, 32'h55, 2);
      rdchk(OFF_PC, 32'h0801); rdchk(OFF_FLAG, 32'h55);
      run(OP_RELATIVE_SUBROUTINE_CALL, 32'h0, 32'h1000, 32'h55, 3);
      rdchk(OFF_PC, 32'h0801); rdchk(OFF_STK, 32'h1001); rdchk(OFF_FLAG, 32'h55);
      apb(1'b1, OFF_ZPTR, 32'h1234);
      run(OP_INDIRECT_JUMP, 32'h0, 32'h10, 32'h0, 2);
      rdchk(OFF_PC, 32'h1234);
      run(OP_INDIRECT_CALL, 32'h0, 32'h10, 32'h0, 3);
      rdchk(OFF_PC, 32'h1234); rdchk(OFF_STK, 32'h11);
      run(OP_CALL_EXIT, 32'h0, 32'h10, 32'h0, 4);
      rdchk(OFF_PC, 32'h11); rdchk(OFF_FLAG, 32'h0);
      apb(1'b1, OFF_STK, 32'h40);
      run(OP_INTERRUPT_EXIT, 32'h0, 32'h10, 32'h0, 4);
      rdchk(OFF_PC, 32'h40); rdchk(OFF_FLAG, 32'h80);
      run(OP_COMPARE_REGISTERS, 32'h0605, 32'h10, 32'h10, 1);
      rdchk(OFF_FLAG, 32'h35);
      run(OP_COMPARE_WITH_CARRY, 32'h0405, 32'h10, 32'h03, 1);
      rdchk(OFF_FLAG, 32'h02);
      run(OP_COMPARE_IMMEDIATE, 32'h1010, 32'h10, 32'h3f, 1);
      rdchk(OFF_FLAG, 32'h12);
      run(OP_COMPARE_SKIP_EQUAL, 32'h3433, 32'h10, 32'h0, 1);
      rdchk(OFF_PC, 32'h11);
      run(OP_COMPARE_SKIP_EQUAL, 32'h08003333, 32'h10, 32'h0, 3);
      rdchk(OFF_PC, 32'h13);
      run(OP_SKIP_REG_BIT_SET, 32'h0b000800, 32'h10, 32'h0, 3);
      rdchk(OFF_PC, 32'h13);
      run(OP_SKIP_IO_BIT_CLEAR, 32'h00fe0000, 32'h10, 32'h0, 2);
      rdchk(OFF_PC, 32'h12);
      apb(1'b1, OFF_KOFF, 32'h4);
      // every branch, once with its flag set and once with it clear
      for (int i = 0; i < 19; i++) begin
         for (int j = 0; j < 2; j++) begin
            tk = ~(j[0] ^ pol[i]);
            run(bmeu_op_t'(18 + i), 32'h06000000, 32'h10, j ? msk[i] : 8'h00, tk ? 2 : 1);
            rdchk(OFF_PC, tk ? 32'h15 : 32'h11);
            rdchk(OFF_FLAG, j ? msk[i] : 8'h00);
         end
      end
      apb(1'b1, OFF_PROD, 32'h1);
      chk(er, 1'b1);
      rdchk(8'h24, 32'h0);
      chk(er, 1'b1);
      end_of_test;
   end
endmodule
